// ### rtl/adc_conversion_launch_control_defines.vh
`ifndef ADC_CONVERSION_LAUNCH_CONTROL_DEFINES_VH
`define ADC_CONVERSION_LAUNCH_CONTROL_DEFINES_VH

// Register byte addresses
`define ADDR_CONTROL_ONE 8'h10
`define ADDR_CONTROL_TWO 8'h11
`define ADDR_CONTROL_FOUR 8'h13
`define ADDR_RESULT_HIGH 8'h14
`define ADDR_RESULT_LOW 8'h15

// Field positions in the first control register
`define BIT_DONE_FLAG 7
`define BIT_IRQ_ENABLE 6
`define BIT_CONTINUOUS 5
`define CHAN_MSB 4

// Field positions in the second control register
`define BIT_ACTIVE 7
`define BIT_HW_TRIGGER 6
`define BIT_COMPARE_EN 5

// Top bit of the depth setting field in the fourth control register
`define DEPTH_MSB 2

// Reset values
`define RESET_CONTROL_ONE 8'h1f
`define RESET_CONTROL_TWO 8'h00
`define RESET_CONTROL_FOUR 8'h00

// Channel codes
`define CHAN_DISABLED 5'h1f
`define CHAN_GROUND_FIRST 5'h0c
`define CHAN_GROUND_LAST 5'h13

// Queue sizing
`define QUEUE_ENTRIES 8
`define QUEUE_PTR_MSB 2
`define QUEUE_COUNT_MSB 3

`endif

// ### rtl/adc_conversion_launch_control.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_conversion_launch_control_defines.vh"

module adc_conversion_launch_control (
  input wire clk_sys,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire hardware_trigger_input,
  input wire conv_done,
  input wire conv_compare_true,
  input wire [11:0] conv_result,
  output reg conv_start,
  output reg conv_abort,
  output reg [4:0] conv_channel,
  output reg conv_ground_sel,
  output reg conv_active,
  output reg done_irq
);

  // Register fields
  reg conversion_done_flag_q;
  reg conversion_done_flag_d;
  reg done_interrupt_enable_q;
  reg continuous_conversion_bit_q;
  reg [4:0] channel_selector_q;
  reg hw_trigger_mode_q;
  reg compare_function_enable_q;
  reg [`DEPTH_MSB:0] fifo_depth_setting_q;

  // Channel queue
  reg [4:0] queue_mem [0:`QUEUE_ENTRIES-1];
  reg [`QUEUE_COUNT_MSB:0] queue_count_q;
  reg [`QUEUE_COUNT_MSB:0] queue_count_d;
  reg [`QUEUE_PTR_MSB:0] queue_idx_q;
  reg [`QUEUE_PTR_MSB:0] queue_idx_d;
  reg queue_push;
  reg [`QUEUE_PTR_MSB:0] queue_push_ptr;

  // Sequencer
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_BUSY = 2'h2;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg set_hit_q;
  reg set_hit_d;
  reg start_d;
  reg abort_d;
  reg [4:0] start_chan_d;
  reg flag_set;
  reg flag_clear;

  // Trigger pin synchroniser and edge detect
  reg trig_meta_q;
  reg trig_sync_q;
  reg trig_prev_q;
  wire trig_event;

  wire wr_ctl1 = reg_write && (reg_addr == `ADDR_CONTROL_ONE);
  wire wr_ctl2 = reg_write && (reg_addr == `ADDR_CONTROL_TWO);
  wire wr_ctl4 = reg_write && (reg_addr == `ADDR_CONTROL_FOUR);
  wire rd_low = reg_read && (reg_addr == `ADDR_RESULT_LOW);
  wire [4:0] wr_chan = reg_wdata[`CHAN_MSB:0];
  wire wr_disable = (wr_chan == `CHAN_DISABLED);
  wire fifo_mode = (fifo_depth_setting_q != {(`DEPTH_MSB+1){1'b0}});
  wire [`QUEUE_COUNT_MSB:0] depth_ext = {1'b0, fifo_depth_setting_q};
  wire [`QUEUE_PTR_MSB:0] last_idx = fifo_depth_setting_q - 1'b1;
  wire wr_continuous = reg_wdata[`BIT_CONTINUOUS];
  wire result_ok = !compare_function_enable_q || conv_compare_true;

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      trig_meta_q <= 1'b0;
      trig_sync_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_meta_q <= hardware_trigger_input;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  assign trig_event = trig_sync_q && !trig_prev_q;

  // Selector map: 0-11 external inputs, 12-19 ground
  function ground_code;
    input [4:0] code;
    begin
      ground_code = (code >= `CHAN_GROUND_FIRST) && (code <= `CHAN_GROUND_LAST);
    end
  endfunction

  // Sequencer next state
  always @*
  begin
    state_d = state_q;
    queue_count_d = queue_count_q;
    queue_idx_d = queue_idx_q;
    set_hit_d = set_hit_q;
    queue_push = 1'b0;
    queue_push_ptr = queue_count_q[`QUEUE_PTR_MSB:0];
    start_d = 1'b0;
    abort_d = 1'b0;
    start_chan_d = channel_selector_q;
    flag_set = 1'b0;
    flag_clear = wr_ctl1 || rd_low;

    if (wr_ctl1)
    begin
      abort_d = (state_q == ST_BUSY);
      if (wr_disable)
      begin
        queue_count_d = {(`QUEUE_COUNT_MSB+1){1'b0}};
        queue_idx_d = {(`QUEUE_PTR_MSB+1){1'b0}};
        state_d = ST_IDLE;
      end
      else if (fifo_mode)
      begin
        // A write to an already filled queue begins a new sequence
        if (queue_count_q >= depth_ext)
        begin
          queue_push_ptr = {(`QUEUE_PTR_MSB+1){1'b0}};
          queue_count_d = {{`QUEUE_COUNT_MSB{1'b0}}, 1'b1};
        end
        else
        begin
          queue_count_d = queue_count_q + 1'b1;
        end
        queue_push = 1'b1;
        queue_idx_d = {(`QUEUE_PTR_MSB+1){1'b0}};
        set_hit_d = 1'b0;
        state_d = ST_IDLE;
        if (queue_count_d == depth_ext)
        begin
          if (hw_trigger_mode_q)
            state_d = ST_ARMED;
          else
          begin
            start_d = 1'b1;
            start_chan_d = (queue_push_ptr == {(`QUEUE_PTR_MSB+1){1'b0}}) ?
                           wr_chan : queue_mem[0];
            state_d = ST_BUSY;
          end
        end
      end
      else if (hw_trigger_mode_q)
        state_d = ST_ARMED;
      else
      begin
        start_d = 1'b1;
        start_chan_d = wr_chan;
        state_d = ST_BUSY;
      end
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_d = ST_IDLE;
        ST_ARMED:
        begin
          if (trig_event)
          begin
            start_d = 1'b1;
            start_chan_d = fifo_mode ? queue_mem[0] : channel_selector_q;
            queue_idx_d = {(`QUEUE_PTR_MSB+1){1'b0}};
            set_hit_d = 1'b0;
            state_d = ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (conv_done)
          begin
            if (fifo_mode)
            begin
              set_hit_d = set_hit_q || result_ok;
              if (queue_idx_q == last_idx)
              begin
                flag_set = set_hit_q || result_ok;
                queue_idx_d = {(`QUEUE_PTR_MSB+1){1'b0}};
                set_hit_d = 1'b0;
                if (continuous_conversion_bit_q)
                begin
                  start_d = 1'b1;
                  start_chan_d = queue_mem[0];
                end
                else
                  state_d = hw_trigger_mode_q ? ST_ARMED : ST_IDLE;
              end
              else
              begin
                queue_idx_d = queue_idx_q + 1'b1;
                start_d = 1'b1;
                start_chan_d = queue_mem[queue_idx_d];
              end
            end
            else
            begin
              flag_set = result_ok;
              if (continuous_conversion_bit_q)
              begin
                start_d = 1'b1;
                start_chan_d = channel_selector_q;
              end
              else
                state_d = hw_trigger_mode_q ? ST_ARMED : ST_IDLE;
            end
          end
        end
        default:
          state_d = ST_IDLE;
      endcase
    end

    // A completion landing with a result-low read still sets the flag
    conversion_done_flag_d = flag_set ? 1'b1 :
                             (flag_clear ? 1'b0 : conversion_done_flag_q);
  end

  // Queue storage has no reset; entries are only read below the count
  always @(posedge clk_sys)
  begin
    if (queue_push)
      queue_mem[queue_push_ptr] <= wr_chan;
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      conversion_done_flag_q <= 1'b0;
      done_interrupt_enable_q <= 1'b0;
      continuous_conversion_bit_q <= 1'b0;
      channel_selector_q <= `CHAN_DISABLED;
      hw_trigger_mode_q <= 1'b0;
      compare_function_enable_q <= 1'b0;
      fifo_depth_setting_q <= {(`DEPTH_MSB+1){1'b0}};
      state_q <= ST_IDLE;
      queue_count_q <= {(`QUEUE_COUNT_MSB+1){1'b0}};
      queue_idx_q <= {(`QUEUE_PTR_MSB+1){1'b0}};
      set_hit_q <= 1'b0;
    end
    else
    begin
      conversion_done_flag_q <= conversion_done_flag_d;
      state_q <= state_d;
      queue_count_q <= queue_count_d;
      queue_idx_q <= queue_idx_d;
      set_hit_q <= set_hit_d;
      if (wr_ctl1)
      begin
        done_interrupt_enable_q <= reg_wdata[`BIT_IRQ_ENABLE];
        continuous_conversion_bit_q <= wr_continuous;
        channel_selector_q <= wr_chan;
      end
      if (wr_ctl2)
      begin
        hw_trigger_mode_q <= reg_wdata[`BIT_HW_TRIGGER];
        compare_function_enable_q <= reg_wdata[`BIT_COMPARE_EN];
      end
      if (wr_ctl4)
      begin
        fifo_depth_setting_q <= reg_wdata[`DEPTH_MSB:0];
      end
    end
  end

  // Converter and status outputs, all registered
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_channel <= `CHAN_DISABLED;
      conv_ground_sel <= 1'b0;
      conv_active <= 1'b0;
      done_irq <= 1'b0;
    end
    else
    begin
      conv_start <= start_d;
      conv_abort <= abort_d;
      if (start_d)
      begin
        conv_channel <= start_chan_d;
        conv_ground_sel <= ground_code(start_chan_d);
      end
      conv_active <= (state_d == ST_BUSY);
      done_irq <= conversion_done_flag_d &&
                  (wr_ctl1 ? reg_wdata[`BIT_IRQ_ENABLE] : done_interrupt_enable_q);
    end
  end

  // Read port; only a result-low read has a side effect
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_read)
    begin
      case (reg_addr)
        `ADDR_CONTROL_ONE:
        begin
          reg_rdata <= {conversion_done_flag_q, done_interrupt_enable_q,
                        continuous_conversion_bit_q, channel_selector_q};
        end
        `ADDR_CONTROL_TWO:
        begin
          reg_rdata <= {conv_active, hw_trigger_mode_q, compare_function_enable_q, 5'h00};
        end
        `ADDR_CONTROL_FOUR:
        begin
          reg_rdata <= {5'h00, fifo_depth_setting_q};
        end
        `ADDR_RESULT_HIGH:
        begin
          reg_rdata <= {4'h0, conv_result[11:8]};
        end
        `ADDR_RESULT_LOW:
        begin
          reg_rdata <= conv_result[7:0];
        end
        default:
        begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // adc_conversion_launch_control

`default_nettype wire

// ### verif/adc_launch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adc_launch_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic conv_done,
  input wire logic conv_compare_true,
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  input wire logic conv_ground_sel,
  input wire logic conv_active,
  input wire logic done_irq
);
  logic [7:0] ctl_q;
  logic [7:0] mode_q;
  logic [2:0] depth_q;
  logic wr1;
  assign wr1 = reg_write && reg_addr == 8'h10;
  // Shadow copies so the start, restart, irq and compare properties know the mode they run in
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ctl_q <= 8'h1f;
      mode_q <= 8'h00;
      depth_q <= 3'h0;
    end
    else if (reg_write)
    begin
      if (reg_addr == 8'h10)
        ctl_q <= reg_wdata;
      if (reg_addr == 8'h11)
        mode_q <= reg_wdata;
      if (reg_addr == 8'h13)
        depth_q <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_write_starts: assert property (
    wr1 && reg_wdata[4:0] != 5'h1f && depth_q == 3'h0 && !mode_q[6]
    |=> conv_start && conv_channel == $past(reg_wdata[4:0])) else $error("no start");
  a_stop_write: assert property (
    wr1 && reg_wdata[4:0] == 5'h1f |=> !conv_start && !conv_active) else $error("no halt");
  a_cont_again: assert property (
    conv_done && conv_active && ctl_q[5] && depth_q == 3'h0 && !reg_write |=> conv_start)
    else $error("no restart");
  a_flag_irq: assert property (
    conv_done && conv_active && depth_q == 3'h0 && !mode_q[5] && ctl_q[6] && !reg_write
    |=> done_irq) else $error("no irq");
  a_cmp_false: assert property (
    conv_done && mode_q[5] && !conv_compare_true && depth_q == 3'h0 && !done_irq
    && !reg_write |=> !done_irq) else $error("irq on false compare");
  a_irq_cause: assert property (
    $rose(done_irq) |-> $past(conv_done)) else $error("irq without done");
  a_flag_clear: assert property (
    (wr1 || reg_read && reg_addr == 8'h15) && !conv_done |=> !done_irq) else $error("irq kept");
  a_ground_map: assert property (
    conv_ground_sel == (conv_channel >= 5'h0c && conv_channel <= 5'h13)) else $error("ground");
endmodule // adc_launch_monitor
bind adc_conversion_launch_control adc_launch_monitor i_monitor (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .conv_done(conv_done),
  .conv_compare_true(conv_compare_true), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_ground_sel(conv_ground_sel),
  .conv_active(conv_active), .done_irq(done_irq)
);
`default_nettype wire

// ### verif/conv_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_core_model #(parameter int LAT = 4) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [4:0] conv_channel,
  input wire logic cmp_in,
  output logic conv_done,
  output logic conv_compare_true,
  output logic [11:0] conv_result
);
  int cnt;
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 0;
      conv_done <= 1'b0;
      conv_compare_true <= 1'b0;
    end
    else
    begin
      conv_done <= cnt == 1;
      // Compare only valid with done; toggling so nothing relies on it otherwise
      conv_compare_true <= (cnt == 1) ? cmp_in : ~conv_compare_true;
      if (conv_start)
        cnt <= LAT;
      else if (conv_abort)
        cnt <= 0;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
  assign conv_result = {7'h5a, conv_channel};
endmodule // conv_core_model
`default_nettype wire

// ### verif/adc_conversion_launch_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_launch_control_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic trig = 1'b0;
  logic cmp_in = 1'b0;
  logic [7:0] rdata, d;
  logic [11:0] result;
  logic [4:0] chan;
  logic done, cmp, start, abort, gsel, active, irq;
  int mismatches = 0;
  int check_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  adc_conversion_launch_control i_dut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata),
    .hardware_trigger_input(trig), .conv_done(done), .conv_compare_true(cmp),
    .conv_result(result), .conv_start(start), .conv_abort(abort), .conv_channel(chan),
    .conv_ground_sel(gsel), .conv_active(active), .done_irq(irq)
  );
  conv_core_model i_core (
    .clk_sys(clk_sys), .reset(reset), .conv_start(start), .conv_abort(abort),
    .conv_channel(chan), .cmp_in(cmp_in), .conv_done(done), .conv_compare_true(cmp),
    .conv_result(result)
  );
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [11:0] g, logic [11:0] e);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = rdata;
  endtask
  // Done waits one edge more so the flag has landed
  task automatic wt(bit for_done);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (!for_done && start)
        return;
      if (for_done && done)
      begin
        @(posedge clk_sys);
        #1;
        return;
      end
    end
    mismatches++;
    wrap_up;
  endtask
  task automatic t_single;
    wr(8'h10, 8'h45);
    chk("start", {start, chan}, {1'b1, 5'h05});
    wt(1'b1);
    chk("irq", irq, 1'b1);
    rd(8'h10);
    chk("ctl done", d, 8'hc5);
    chk("irq kept", irq, 1'b1);
    chk("idle", {active, start}, 2'b00);
    rd(8'h1e);
    chk("unmapped", d, 8'h00);
    rd(8'h15);
    chk("irq cleared", irq, 1'b0);
  endtask
  task automatic t_abort;
    wr(8'h10, 8'h03);
    wr(8'h10, 8'h07);
    chk("abort", {abort, start, chan}, {2'b11, 5'h07});
    wr(8'h10, 8'h1f);
    chk("halt", {active, start}, 2'b00);
  endtask
  task automatic t_ground;
    logic [4:0] c [4] = '{5'h0b, 5'h0c, 5'h13, 5'h14};
    foreach (c[i])
    begin
      wr(8'h10, {3'b000, c[i]});
      chk("ground", gsel, c[i] >= 5'h0c && c[i] <= 5'h13);
    end
    wr(8'h10, 8'h1f);
  endtask
  task automatic t_cont;
    wr(8'h10, 8'h22);
    repeat (2)
    begin
      wt(1'b1);
      chk("again", {start, chan}, {1'b1, 5'h02});
    end
    wr(8'h10, 8'h1f);
  endtask
  task automatic t_cmp;
    wr(8'h11, 8'h20);
    wr(8'h10, 8'h44);
    wt(1'b1);
    chk("cmp false", irq, 1'b0);
    @(posedge clk_sys);
    cmp_in <= 1'b1;
    wr(8'h10, 8'h44);
    wt(1'b1);
    chk("cmp true", irq, 1'b1);
    wr(8'h11, 8'h00);
  endtask
  task automatic t_fifo;
    wr(8'h13, 8'h02);
    wr(8'h10, 8'h43);
    wr(8'h10, 8'h1f);
    chk("flushed", {active, start}, 2'b00);
    // A stale entry would fill the queue on the next write
    wr(8'h10, 8'h43);
    chk("fill", start, 1'b0);
    wr(8'h10, 8'h46);
    chk("first", {start, chan}, {1'b1, 5'h03});
    wt(1'b1);
    chk("mid set", irq, 1'b0);
    wt(1'b1);
    chk("set end", {irq, chan}, {1'b1, 5'h06});
    wr(8'h10, 8'h21);
    wr(8'h10, 8'h22);
    chk("loop first", {start, chan}, {1'b1, 5'h01});
    wt(1'b1);
    chk("loop mid", {start, chan}, {1'b1, 5'h02});
    wt(1'b1);
    chk("loop again", {start, chan}, {1'b1, 5'h01});
    wr(8'h10, 8'h1f);
    wr(8'h13, 8'h00);
  endtask
  task automatic t_hw;
    wr(8'h11, 8'h40);
    wr(8'h10, 8'h08);
    chk("armed", start, 1'b0);
    @(posedge clk_sys);
    trig <= 1'b1;
    wt(1'b0);
    chk("hw start", chan, 5'h08);
    wt(1'b1);
    chk("one only", {active, start}, 2'b00);
    @(posedge clk_sys);
    trig <= 1'b0;
    wr(8'h11, 8'h00);
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h10);
    chk("ctl reset", d, 8'h1f);
    t_single;
    t_abort;
    t_ground;
    t_cont;
    t_cmp;
    t_fifo;
    t_hw;
    wrap_up;
  end
endmodule // adc_conversion_launch_control_tb
`default_nettype wire
